//--- src/iicms_regs.svh
// Register offsets, field positions, reset values and timing counts of the mode/status block
`ifndef IICMS_REGS_SVH
`define IICMS_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IICMS_OFS_TXDATA 9'h194
`define IICMS_OFS_RXDATA 9'h195
`define IICMS_OFS_CTRL 9'h198
`define IICMS_OFS_MODE 9'h19a
`define IICMS_OFS_IRQEN 9'h19b
`define IICMS_OFS_STAT 9'h19c
`define IICMS_OFS_SADDR 9'h19d

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IICMS_MODE_ORDER 7
`define IICMS_MODE_WAIT 6
`define IICMS_MODE_BIT_COUNTER_WRITE_PROTECT 3
`define IICMS_CTRL_ENABLE 7
`define IICMS_CTRL_MST 5
`define IICMS_CTRL_TRS 4
`define IICMS_SADDR_FMT 0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define IICMS_MODE_RST 8'h18
`define IICMS_IRQEN_RST 8'h00
`define IICMS_STAT_RST 8'h00
`define IICMS_SCL_HALF 14
`define IICMS_WAIT_FACTOR 3

`endif

//--- src/iicms_pkg.sv
// Types shared by the mode/status block
package iicms_pkg;

	// Status flags in register bit order, bit 7 first
	typedef struct packed {
		logic tx_empty_flag;
		logic tx_end_flag;
		logic rx_full_flag;
		logic no_ack_flag;
		logic stop_flag;
		logic arb_lost_overrun_flag;
		logic own_address_match_flag;
		logic general_call_flag;
	} iicms_stat_t;

	// Interrupt enables and acknowledge control, bit 7 first
	typedef struct packed {
		logic tx_empty_irq_enable;
		logic tx_end_irq_enable;
		logic rx_irq_enable;
		logic nack_irq_enable;
		logic stop_irq_enable;
		logic ack_check_enable;
		logic ack_received;
		logic ack_to_send;
	} iicms_irqen_t;

	// Master clock generator states
	typedef enum logic [2:0] {
		IICMS_CK_IDLE = 3'b001,
		IICMS_CK_LOW = 3'b010,
		IICMS_CK_HIGH = 3'b100
	} iicms_ck_state_t;

endpackage : iicms_pkg

//--- src/iicms_core.sv
// Mode, interrupt-enable and status logic of the I2C / clock synchronous serial interface
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "iicms_regs.svh"

// Functional notes
// [RULE1] Bit counter returns to 000b after each frame with acknowledge and on start.
// [RULE2] Software changes the counter between frames, nonzero values only with clock low.
// [RULE3] Counter write takes effect only with protect bit 0; protect bit reads 1.
// [RULE4] I2C: 000 is nine bits, else code+1; synchronous: 000 is eight, else code.
// [RULE5] Wait bit stretches clock low before acknowledge, only as I2C master.
// [RULE6] Bit order select: 0 MSB first, 1 LSB first.
// [RULE7] Receiver drives acknowledge slot with the acknowledge-to-send bit.
// [RULE8] Transmitter captures returned acknowledge into the read-only received bit.
// [RULE9] With checking on, received acknowledge 1 halts continuous transfer.
// [RULE10] Software enables stop interrupt only while stop flag is 0.
// [RULE11] One NACK enable gates no-acknowledge and arbitration-lost/overrun requests.
// [RULE12] Receive enable gates receive-full and, synchronous format, overrun requests.
// [RULE13] Own enables gate transmit-empty and transmit-end requests.
// [RULE14] Slave receive, I2C: general call in first frame sets general-call flag.
// [RULE15] Slave receive: own address or general call in first frame sets match flag.
// [RULE16] I2C: data mismatch at clock rise as master transmitter sets arbitration lost.
// [RULE17] Synchronous: last bit arriving with receive-full still set flags overrun.
// [RULE18] Stop after a transferred frame sets stop flag.
// [RULE19] Missing acknowledge after transmit sets no-ack flag when checking enabled.
// [RULE20] Receive-full sets on move into holding register, clears on its read.
// [RULE21] Transmit-end sets at 9th clock rise with empty set, or after last bit.
// [RULE22] Transmit-empty sets on reload, transmit mode, start, slave receive to transmit.
// [RULE23] Writing transmit data clears transmit-empty and transmit-end.
// [RULE24] Status register writes clear a flag only by writing 0 after reading 1.
// [RULE25] Each request is enable AND flag; stop and nack absent in synchronous format.
// [RULE26] Format bit: 0 I2C, 1 clock synchronous serial.
module iicms_core import iicms_pkg::*; #(
	parameter int SCL_HALF = `IICMS_SCL_HALF
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [8:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic tx_empty_irq_o,
	output logic tx_end_irq_o,
	output logic rx_full_irq_o,
	output logic stop_detect_irq_o,
	output logic nack_arb_irq_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Bits in a frame, acknowledge included for I2C
	function automatic logic [3:0] frame_len(input logic [2:0] bc, input logic csync);
		if (bc == 3'h0) begin
			frame_len = csync ? 4'h8 : 4'h9; // [RULE4]
		end else begin
			frame_len = csync ? {1'b0, bc} : {1'b0, bc} + 4'h1; // [RULE4]
		end
	endfunction : frame_len

	function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic ice_q, mst_q, trs_q, fs_q, order_q, wait_q;
	logic [2:0] bc_q;
	logic [6:0] sva_q;
	iicms_irqen_t ien_q;
	iicms_stat_t stat_q, stat_set, stat_clr;
	logic [7:0] seen_q, tx_hold_q, rx_hold_q, shift_q, sh_nx;
	logic tx_full_q, shift_loaded_q, first_q, addressed_q, framed_q;
	logic [3:0] bitn_q, len;
	iicms_ck_state_t ck_q;
	logic [15:0] cnt_q;
	logic [7:0] rdata_d;

	logic csync, scl_rise, start_det, stop_det, last, ack_slot, data_done, frame_done;
	logic part, halt, go, wait_now, load_shift, txbit, want_oe;
	logic wr_ctrl, wr_mode, wr_stat, wr_tx, rd_rx, rd_stat, bc_wr, addr_match, gen_call;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two stages before use, third holds previous value for edge finding
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// ----------------------------------------
	// Decode and frame events
	// ----------------------------------------
	assign wr_ctrl = wr_i && hit(addr_i, `IICMS_OFS_CTRL);
	assign wr_mode = wr_i && hit(addr_i, `IICMS_OFS_MODE);
	assign wr_stat = wr_i && hit(addr_i, `IICMS_OFS_STAT);
	assign wr_tx = wr_i && hit(addr_i, `IICMS_OFS_TXDATA);
	assign rd_rx = rd_i && hit(addr_i, `IICMS_OFS_RXDATA);
	assign rd_stat = rd_i && hit(addr_i, `IICMS_OFS_STAT);
	assign bc_wr = wr_mode && !wdata_i[`IICMS_MODE_BIT_COUNTER_WRITE_PROTECT]; // [RULE3]
	assign csync = fs_q; // [RULE26]
	assign scl_rise = scl_s_q && !scl_p_q;
	assign start_det = !csync && scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
	assign stop_det = !csync && scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
	assign len = frame_len(bc_q, csync);
	assign last = (bitn_q == len - 4'h1);
	assign ack_slot = !csync && last;
	assign part = ice_q && (csync || mst_q || addressed_q || first_q);
	assign data_done = scl_rise && part && (csync ? last : (bitn_q == len - 4'h2));
	assign frame_done = scl_rise && part && last;
	assign halt = ien_q.ack_check_enable && stat_q.no_ack_flag; // [RULE9]
	assign go = ice_q && mst_q && !halt && (trs_q ? shift_loaded_q : !stat_q.rx_full_flag);
	assign wait_now = !csync && mst_q && wait_q && last; // [RULE5]
	assign load_shift = trs_q && tx_full_q && !shift_loaded_q && (bitn_q == 4'h0);
	assign txbit = order_q ? shift_q[0] : shift_q[7]; // [RULE6]
	assign sh_nx = order_q ? {sda_s_q, shift_q[7:1]} : {shift_q[6:0], sda_s_q}; // [RULE6]
	assign gen_call = (sh_nx == 8'h00);
	assign addr_match = data_done && first_q && !mst_q && !trs_q && !csync && ice_q
		&& (sh_nx[7:1] == sva_q || gen_call);

	// ----------------------------------------
	// Control, format and mode registers
	// ----------------------------------------
	// Mode, slave address and bus enable fields
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ice_q <= 1'b0;
			fs_q <= 1'b0;
			sva_q <= 7'h00;
			order_q <= 1'b0;
			wait_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ice_q <= wdata_i[`IICMS_CTRL_ENABLE];
			end
			if (wr_i && hit(addr_i, `IICMS_OFS_SADDR)) begin
				fs_q <= wdata_i[`IICMS_SADDR_FMT];
				sva_q <= wdata_i[7:1];
			end
			if (wr_mode) begin
				order_q <= wdata_i[`IICMS_MODE_ORDER];
				wait_q <= wdata_i[`IICMS_MODE_WAIT];
			end
		end
	end

	// Master and direction bits; hardware drops or turns them on bus events
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mst_q <= 1'b0;
			trs_q <= 1'b0;
		end else if (stat_set.arb_lost_overrun_flag) begin
			mst_q <= 1'b0;
			trs_q <= csync ? trs_q : 1'b0;
		end else if (addr_match && sh_nx[0] && !gen_call) begin
			trs_q <= 1'b1;
		end else if (wr_ctrl) begin
			mst_q <= wdata_i[`IICMS_CTRL_MST];
			trs_q <= wdata_i[`IICMS_CTRL_TRS];
		end
	end

	// Bit counter: hardware return to 000b wins over a software load
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bc_q <= 3'h0;
		end else if (start_det || frame_done) begin
			bc_q <= 3'h0; // [RULE1]
		end else if (bc_wr) begin
			bc_q <= wdata_i[2:0]; // [RULE3]
		end
	end

	// Interrupt enables, acknowledge control and captured acknowledge
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ien_q <= iicms_irqen_t'(`IICMS_IRQEN_RST);
		end else begin
			if (wr_i && hit(addr_i, `IICMS_OFS_IRQEN)) begin
				ien_q <= {wdata_i[7:2], ien_q.ack_received, wdata_i[0]};
			end
			if (frame_done && ack_slot && trs_q) begin
				ien_q.ack_received <= sda_s_q; // [RULE8]
			end
		end
	end

	// ----------------------------------------
	// Frame tracking and data path
	// ----------------------------------------
	// Bit position, first-frame and addressed tracking
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bitn_q <= 4'h0;
			first_q <= 1'b0;
			addressed_q <= 1'b0;
			framed_q <= 1'b0;
		end else if (start_det || stop_det) begin
			bitn_q <= 4'h0;
			first_q <= start_det;
			addressed_q <= 1'b0;
			framed_q <= 1'b0;
		end else if (scl_rise && part) begin
			bitn_q <= last ? 4'h0 : bitn_q + 4'h1;
			first_q <= last ? 1'b0 : first_q;
			framed_q <= framed_q || last;
			addressed_q <= addressed_q || addr_match;
		end
	end

	// Shift register, transmit and receive holding registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= 8'h00;
			tx_hold_q <= 8'hff;
			rx_hold_q <= 8'h00;
			tx_full_q <= 1'b0;
			shift_loaded_q <= 1'b0;
		end else begin
			if (wr_tx) begin
				tx_hold_q <= wdata_i;
				tx_full_q <= 1'b1;
			end else if (load_shift) begin
				tx_full_q <= 1'b0;
			end
			if (load_shift) begin
				shift_q <= tx_hold_q;
				shift_loaded_q <= 1'b1;
			end else if (scl_rise && part && !ack_slot) begin
				shift_q <= sh_nx;
			end
			if (frame_done || start_det || !trs_q) begin
				shift_loaded_q <= 1'b0;
			end
			if (data_done && !trs_q) begin
				rx_hold_q <= sh_nx; // [RULE20]
			end
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Set and clear terms; a set in the clearing cycle wins
	always_comb begin
		stat_set = '0;
		stat_clr = '0;
		stat_set.tx_empty_flag = load_shift || (wr_ctrl && wdata_i[`IICMS_CTRL_TRS] && !trs_q)
			|| (start_det && mst_q) || (addr_match && sh_nx[0] && !gen_call); // [RULE22]
		stat_set.tx_end_flag = frame_done && trs_q && stat_q.tx_empty_flag
			&& (csync || bitn_q == 4'h8); // [RULE21]
		stat_set.rx_full_flag = data_done && !trs_q; // [RULE20]
		stat_set.no_ack_flag = frame_done && ack_slot && trs_q && sda_s_q
			&& ien_q.ack_check_enable; // [RULE19]
		stat_set.stop_flag = stop_det && framed_q; // [RULE18]
		stat_set.arb_lost_overrun_flag = (!csync && mst_q && trs_q && scl_rise && !ack_slot
			&& (sda_s_q != !sda_oe_o)) || (start_det && mst_q && sda_s_q) // [RULE16]
			|| (csync && data_done && !trs_q && stat_q.rx_full_flag); // [RULE17]
		stat_set.own_address_match_flag = addr_match; // [RULE15]
		stat_set.general_call_flag = addr_match && gen_call; // [RULE14]
		if (wr_stat) begin
			stat_clr = iicms_stat_t'(seen_q & ~wdata_i); // [RULE24]
		end
		if (wr_tx) begin
			stat_clr.tx_empty_flag = 1'b1; // [RULE23]
			stat_clr.tx_end_flag = 1'b1; // [RULE23]
		end
		if (rd_rx) begin
			stat_clr.rx_full_flag = 1'b1; // [RULE20]
		end
	end

	// Sticky flags
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_q <= iicms_stat_t'(`IICMS_STAT_RST);
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_set; // [RULE24]
		end
	end

	// Which flags software has seen at 1; writing 0 to a flag consumes it
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seen_q <= 8'h00;
		end else if (rd_stat) begin
			seen_q <= seen_q | stat_q; // [RULE24]
		end else if (wr_stat) begin
			seen_q <= seen_q & wdata_i;
		end
	end

	// ----------------------------------------
	// Master clock generator
	// ----------------------------------------
	// Drives SCL low and high half periods, stretching before acknowledge
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ck_q <= IICMS_CK_IDLE;
			cnt_q <= 16'h0000;
			scl_oe_o <= 1'b0;
		end else begin
			unique case (ck_q)
				IICMS_CK_IDLE: begin
					cnt_q <= 16'h0000;
					if (go) begin
						ck_q <= IICMS_CK_LOW;
						scl_oe_o <= 1'b1;
					end
				end
				IICMS_CK_LOW: begin
					if (cnt_q >= 16'(wait_now ? `IICMS_WAIT_FACTOR * SCL_HALF - 1 : SCL_HALF - 1)) begin
						ck_q <= IICMS_CK_HIGH; // [RULE5]
						scl_oe_o <= 1'b0;
						cnt_q <= 16'h0000;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				IICMS_CK_HIGH: begin
					if (!mst_q) begin
						ck_q <= IICMS_CK_IDLE;
					end else if (!scl_s_q) begin
						cnt_q <= 16'h0000;
					end else if (cnt_q >= 16'(SCL_HALF - 1)) begin
						cnt_q <= 16'h0000;
						if (bitn_q == 4'h0 && !go) begin
							ck_q <= IICMS_CK_IDLE;
						end else begin
							ck_q <= IICMS_CK_LOW;
							scl_oe_o <= 1'b1;
						end
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Data pin drive
	// ----------------------------------------
	always_comb begin
		want_oe = 1'b0;
		if (csync) begin
			want_oe = ice_q && trs_q && shift_loaded_q;
		end else if (part && ack_slot && (!trs_q || (first_q && !mst_q))) begin
			want_oe = !ien_q.ack_to_send; // [RULE7]
		end else if (part && !ack_slot && trs_q && shift_loaded_q) begin
			want_oe = !txbit;
		end
	end

	// Data changes only while the clock is low
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_oe_o <= 1'b0;
			sda_o <= 1'b0;
			scl_o <= 1'b0;
		end else if (!scl_s_q) begin
			sda_oe_o <= want_oe;
			sda_o <= csync ? txbit : 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupt requests and read port
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_empty_irq_o <= 1'b0;
			tx_end_irq_o <= 1'b0;
			rx_full_irq_o <= 1'b0;
			stop_detect_irq_o <= 1'b0;
			nack_arb_irq_o <= 1'b0;
		end else begin
			tx_empty_irq_o <= ien_q.tx_empty_irq_enable && stat_q.tx_empty_flag; // [RULE13] [RULE25]
			tx_end_irq_o <= ien_q.tx_end_irq_enable && stat_q.tx_end_flag; // [RULE13] [RULE25]
			rx_full_irq_o <= ien_q.rx_irq_enable && (stat_q.rx_full_flag
				|| (csync && stat_q.arb_lost_overrun_flag)); // [RULE12] [RULE25]
			stop_detect_irq_o <= !csync && ien_q.stop_irq_enable && stat_q.stop_flag; // [RULE25]
			nack_arb_irq_o <= ien_q.nack_irq_enable && (stat_q.arb_lost_overrun_flag
				|| (!csync && stat_q.no_ack_flag)); // [RULE11] [RULE25]
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = 8'h00;
		unique case (addr_i)
			`IICMS_OFS_TXDATA: rdata_d = tx_hold_q;
			`IICMS_OFS_RXDATA: rdata_d = rx_hold_q;
			`IICMS_OFS_CTRL: rdata_d = {ice_q, 1'b0, mst_q, trs_q, 4'h0};
			`IICMS_OFS_MODE: rdata_d = {order_q, wait_q, 2'b01, 1'b1, bc_q}; // [RULE3]
			`IICMS_OFS_IRQEN: rdata_d = ien_q;
			`IICMS_OFS_STAT: rdata_d = stat_q;
			`IICMS_OFS_SADDR: rdata_d = {sva_q, fs_q};
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rd_i ? rdata_d : 8'h00;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence seq_ack_rise;
		frame_done && ack_slot && trs_q;
	endsequence
	sequence seq_rx_ack_rise;
		frame_done && ack_slot && !trs_q;
	endsequence

	AST_BC_CLEARED: assert property (start_det |=> bc_q == 3'h0) // [RULE1]
		else $error("bit counter not cleared on start");
	AST_BC_PROTECT: assert property ((wr_mode && wdata_i[3] && !start_det && !frame_done)
		|=> $stable(bc_q)) // [RULE3]
		else $error("protected bit counter write took effect");
	AST_WAIT_HOLD: assert property ((ck_q == IICMS_CK_LOW && wait_now && cnt_q < 16'(SCL_HALF))
		|=> ck_q == IICMS_CK_LOW && scl_oe_o) // [RULE5]
		else $error("clock released early in wait insertion");
	AST_ACK_DRIVE: assert property (seq_rx_ack_rise and (part && !csync)
		|-> sda_oe_o == !ien_q.ack_to_send) // [RULE7]
		else $error("acknowledge slot not driven from ack_to_send");
	AST_ACK_CAPTURE: assert property (seq_ack_rise |=> ien_q.ack_received == $past(sda_s_q)) // [RULE8]
		else $error("returned acknowledge not captured");
	AST_NACK_FLAG: assert property ((seq_ack_rise and (sda_s_q && ien_q.ack_check_enable))
		|=> stat_q.no_ack_flag ##1 !go) // [RULE19]
		else $error("no-ack flag not set or transfer not halted");
	AST_RX_FULL: assert property (data_done && !trs_q |=> stat_q.rx_full_flag
		&& rx_hold_q == $past(sh_nx)) // [RULE20]
		else $error("receive move did not set receive-full");
	AST_TX_WRITE: assert property (wr_tx && !stat_set.tx_empty_flag && !stat_set.tx_end_flag
		|=> !stat_q.tx_empty_flag && !stat_q.tx_end_flag) // [RULE23]
		else $error("transmit write did not clear empty and end");
	AST_CLR_NEEDS_READ: assert property ((wr_stat && !wdata_i[0] && !seen_q[0] && !stat_set[0])
		|=> stat_q[0] == $past(stat_q[0])) // [RULE24]
		else $error("flag cleared without prior read of 1");
	AST_IRQ_GATE: assert property (##1 nack_arb_irq_o == $past(ien_q.nack_irq_enable
		&& (stat_q.arb_lost_overrun_flag || (!csync && stat_q.no_ack_flag)))) // [RULE11]
		else $error("nack request not gated by its enable");
	AST_OVERRUN: assert property (csync && data_done && !trs_q && stat_q.rx_full_flag
		|=> stat_q.arb_lost_overrun_flag) // [RULE17]
		else $error("overrun not flagged");
	AST_STOP_FLAG: assert property (stop_det && framed_q |=> stat_q.stop_flag ##1 stat_q.stop_flag
		|| $past(wr_stat)) // [RULE18]
		else $error("stop flag not set after frame");

endmodule : iicms_core
`default_nettype wire

//--- bench/iicms_peer.sv
// Behavioural I2C master on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module iicms_peer (
	input wire logic sda_i,
	output logic scl_low_o,
	output logic sda_low_o
);
	// Lines released, clock stands still between frames
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	// Park the clock low so that software may load the bit counter
	task automatic park(input logic low);
		scl_low_o = low;
	endtask : park
	// Start: data falls while the clock is high
	task automatic start();
		sda_low_o = 1'b1;
		#24 scl_low_o = 1'b1;
	endtask : start
	// One 48 ns bit slot, data changes in the low phase
	task automatic bit_slot(input logic b, output logic s);
		#12 sda_low_o = !b;
		#12 scl_low_o = 1'b0;
		#12 s = sda_i;
		#12 scl_low_o = 1'b1;
	endtask : bit_slot
	// Eight bits MSB first, then release data and sample the acknowledge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
		bit_slot(1'b1, ack);
	endtask : send_byte
	// Stop: data rises while the clock is high
	task automatic stop();
		#12 sda_low_o = 1'b1;
		#12 scl_low_o = 1'b0;
		#24 sda_low_o = 1'b0;
	endtask : stop
endmodule : iicms_peer
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench of the mode/status block
`timescale 1ns/1ps
`default_nettype none
`include "iicms_regs.svh"
module tb;
	logic clk, rst_n, wr_en, rd_en, ack, scl_oe, sda_o, sda_oe, scl_low, sda_low;
	logic [8:0] addr;
	logic [7:0] wdata, rdata, d;
	logic scl, sda, scl_out, tx_e_irq, tx_end_irq, rx_irq, stop_irq, nack_irq;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	// Rows: write flag, offset, write data, expected read back
	localparam logic [25:0] ROWS [9] = '{
		{1'b0, 9'h19a, 8'h00, 8'h18}, {1'b0, 9'h19b, 8'h00, 8'h00},
		{1'b0, 9'h19c, 8'h00, 8'h00}, {1'b0, 9'h100, 8'h00, 8'h00},
		{1'b1, 9'h19a, 8'h05, 8'h1d}, {1'b1, 9'h19a, 8'h0a, 8'h1d},
		{1'b1, 9'h19a, 8'h00, 8'h18}, {1'b1, 9'h19b, 8'h02, 8'h00},
		{1'b1, 9'h19c, 8'hff, 8'h00}};

	// Open-drain lines with pull-ups
	assign scl = !(scl_low | (scl_oe & !scl_out));
	assign sda = !(sda_low | (sda_oe & !sda_o));

	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end

	iicms_core i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_en),
		.rd_i(rd_en), .rdata_o(rdata), .scl_i(scl), .scl_o(scl_out), .scl_oe_o(scl_oe), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .tx_empty_irq_o(tx_e_irq), .tx_end_irq_o(tx_end_irq),
		.rx_full_irq_o(rx_irq), .stop_detect_irq_o(stop_irq), .nack_arb_irq_o(nack_irq));
	iicms_peer i_peer (.sda_i(sda), .scl_low_o(scl_low), .sda_low_o(sda_low));

	// Verdict and end of run
	task automatic results();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (exp !== got) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask : chk

	// One-cycle register write
	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	// One-cycle register read, data taken in the following cycle
	task automatic rd(input logic [8:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask : rd

	task automatic settle();
		repeat (8) @(posedge clk);
	endtask : settle

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		addr = 9'h000;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		i_peer.park(1'b1);
		foreach (ROWS[i]) begin
			if (ROWS[i][25]) wr(ROWS[i][24:16], ROWS[i][15:8]);
			rd(ROWS[i][24:16], d);
			chk("reg row", ROWS[i][7:0], d);
		end
		i_peer.park(1'b0);
		// Own address frame with acknowledge, stop irq enabled while stop flag is 0
		wr(`IICMS_OFS_SADDR, 8'ha0);
		wr(`IICMS_OFS_CTRL, 8'h80);
		wr(`IICMS_OFS_IRQEN, 8'h28);
		i_peer.start();
		i_peer.send_byte(8'ha0, ack);
		chk("ack", 8'h00, {7'h00, ack});
		wr(`IICMS_OFS_MODE, 8'h03);
		rd(`IICMS_OFS_MODE, d);
		chk("mode", 8'h1b, d);
		settle();
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h22, d);
		chk("rx irq", 8'h01, {7'h00, rx_irq});
		i_peer.stop();
		settle();
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h2a, d);
		chk("stop irq", 8'h01, {7'h00, stop_irq});
		rd(`IICMS_OFS_RXDATA, d);
		chk("rx data", 8'ha0, d);
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h0a, d);
		wr(`IICMS_OFS_STAT, 8'h00);
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h00, d);
		// General call answered with not-acknowledge, clear without read refused
		wr(`IICMS_OFS_IRQEN, 8'h11);
		i_peer.start();
		rd(`IICMS_OFS_MODE, d);
		chk("mode", 8'h18, d);
		i_peer.send_byte(8'h00, ack);
		chk("nack", 8'h01, {7'h00, ack});
		settle();
		wr(`IICMS_OFS_STAT, 8'h00);
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h23, d);
		chk("rx irq", 8'h00, {7'h00, rx_irq});
		chk("nack irq", 8'h00, {7'h00, nack_irq});
		i_peer.stop();
		settle();
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h2b, d);
		wr(`IICMS_OFS_STAT, 8'h00);
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h00, d);
		// Transmit mode sets empty, data write clears it
		wr(`IICMS_OFS_IRQEN, 8'hc0);
		wr(`IICMS_OFS_CTRL, 8'h90);
		settle();
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h80, d);
		chk("tx irq", 8'h01, {7'h00, tx_e_irq});
		// First byte moves on into the empty shift register, so empty sets again
		wr(`IICMS_OFS_TXDATA, 8'h5a);
		settle();
		chk("tx irq", 8'h01, {7'h00, tx_e_irq});
		wr(`IICMS_OFS_TXDATA, 8'ha5);
		settle();
		chk("tx irq", 8'h00, {7'h00, tx_e_irq});
		chk("tx end irq", 8'h00, {7'h00, tx_end_irq});
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h00, d);
		// Master frame of the loaded byte with wait, far side leaves the acknowledge high
		wr(`IICMS_OFS_MODE, 8'h48);
		wr(`IICMS_OFS_IRQEN, 8'h14);
		wr(`IICMS_OFS_CTRL, 8'hb0);
		repeat (700) @(posedge clk);
		rd(`IICMS_OFS_STAT, d);
		chk("stat", 8'h90, d);
		rd(`IICMS_OFS_IRQEN, d);
		chk("irq en", 8'h16, d);
		chk("nack irq", 8'h01, {7'h00, nack_irq});
		results();
	end
endmodule : tb
`default_nettype wire
